//--- design/bfh_pkg.sv
package bfh_pkg;

    // ===========================================================
    // Register byte offsets
    localparam logic [11:0] BFH_OFF_BRIDGE_CTRL = 12'h03C;
    localparam logic [11:0] BFH_OFF_CBUF_STATUS = 12'hF88;
    localparam logic [11:0] BFH_OFF_TMO_CTRL = 12'hFA0;
    localparam logic [11:0] BFH_OFF_ERR_CTRL = 12'h100;
    localparam logic [11:0] BFH_OFF_ERR_STATUS = 12'h104;
    localparam logic [11:0] BFH_OFF_HDR_LOG = 12'h108;
    localparam logic [11:0] BFH_OFF_SEC_HDR_LOG = 12'h10C;
    localparam logic [11:0] BFH_OFF_IRQ_STATUS = 12'h110;
    localparam logic [11:0] BFH_OFF_IRQ_MASK = 12'h114;

    // ===========================================================
    // Field positions
    localparam int BFH_BC_SEC_PERR_RESP = 0;
    localparam int BFH_BC_MASTER_ABORT_MODE = 21;
    localparam int BFH_TC_DISABLE = 5;
    localparam int BFH_TC_LONG = 6;
    localparam int BFH_EC_SERR_EN = 0;
    localparam int BFH_EC_COR_EN = 1;
    localparam int BFH_EC_NF_EN = 2;
    localparam int BFH_EC_FATAL_EN = 3;
    localparam int BFH_EC_PERR_RESP = 4;
    localparam int BFH_EC_POISON_MASK = 5;
    localparam int BFH_EC_POISON_SEV = 6;
    localparam int BFH_EC_SPERR_MASK = 7;
    localparam int BFH_ES_COR_DET = 0;
    localparam int BFH_ES_NF_DET = 1;
    localparam int BFH_ES_FATAL_DET = 2;
    localparam int BFH_ES_DET_PARITY = 3;
    localparam int BFH_ES_MASTER_PAR = 4;
    localparam int BFH_ES_POISONED = 5;
    localparam int BFH_ES_SIG_SYS_ERR = 6;
    localparam int BFH_ES_SEC_MASTER_PAR = 7;
    localparam int BFH_ES_PERR_DET = 8;
    localparam int BFH_ES_ECRC = 9;
    localparam int BFH_ES_FEP_ACTIVE = 10;
    localparam int BFH_ES_SEC_FEP_ACTIVE = 11;
    localparam int BFH_IRQ_CBUF = 0;
    localparam int BFH_IRQ_MSG = 1;
    localparam int BFH_IRQ_ECRC = 2;
    localparam int BFH_IRQ_PERR = 3;

    // ===========================================================
    // Reset values and counts
    localparam logic [31:0] BFH_RST_BRIDGE_CTRL = 32'h0000_0000;
    localparam logic [31:0] BFH_RST_TMO_CTRL = 32'h0000_0040;
    localparam logic [31:0] BFH_RST_ERR_CTRL = 32'h0000_0000;
    localparam int BFH_NUM_BUF = 8;
    localparam int BFH_TMO_SHORT_EXP = 15;
    localparam int BFH_TMO_LONG_EXP = 20;
    localparam int unsigned BFH_TMO_SHORT_CYC = 32'd1 << BFH_TMO_SHORT_EXP;
    localparam int unsigned BFH_TMO_LONG_CYC = 32'd1 << BFH_TMO_LONG_EXP;
    localparam logic [1:0] BFH_MAX_RECLAIM = 2'h3;
    localparam logic [31:0] BFH_ALL_ONES = 32'hFFFF_FFFF;

    // ===========================================================
    // Types
    typedef enum logic [1:0] {
        BFH_BUF_FREE = 2'b00,
        BFH_BUF_WAIT = 2'b01,
        BFH_BUF_REUSE = 2'b10,
        BFH_BUF_STUCK = 2'b11
    } bfh_buf_state_type;

    typedef enum logic [1:0] {
        BFH_TERM_NORMAL = 2'b00,
        BFH_TERM_PARITY = 2'b01,
        BFH_TERM_MABORT = 2'b10,
        BFH_TERM_TABORT = 2'b11
    } bfh_term_type;

    typedef enum logic [2:0] {
        BFH_CPL_SC = 3'b000,
        BFH_CPL_UR = 3'b001,
        BFH_CPL_CA = 3'b100
    } bfh_cpl_status_type;

    typedef enum logic [1:0] {
        BFH_MSG_COR = 2'b00,
        BFH_MSG_NONFATAL = 2'b01,
        BFH_MSG_FATAL = 2'b11
    } bfh_msg_type;

    typedef struct packed {
        logic valid;
        logic sop;
        logic poisoned;
        logic ecrc_err;
        logic is_read_cpl;
        logic [31:0] header;
        logic [31:0] data;
    } bfh_rx_type;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic parity;
    } bfh_fwd_type;

    typedef struct packed {
        logic valid;
        logic is_write;
        bfh_term_type kind;
    } bfh_term_in_type;

    typedef struct packed {
        logic valid;
        bfh_cpl_status_type status;
        logic poisoned;
    } bfh_cpl_out_type;

    typedef struct packed {
        logic valid;
        logic poisoned_write;
        logic [31:0] header;
    } bfh_perr_type;

    typedef struct packed {
        logic valid;
        bfh_msg_type kind;
    } bfh_msg_out_type;

    typedef struct packed {
        logic valid;
        logic target_abort;
        logic [31:0] data;
    } bfh_rsp_type;

endpackage

//--- design/bfh_fault_handler.sv
`timescale 1ns/10ps
`default_nettype none

module bfh_fault_handler #(
    parameter int unsigned TMO_SHORT_CYC = bfh_pkg::BFH_TMO_SHORT_CYC,
    parameter int unsigned TMO_LONG_CYC = bfh_pkg::BFH_TMO_LONG_CYC
) (
    input wire logic pclk, // Bus and PCI clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic irq, // Level interrupt
    input wire logic alloc_valid, // Reserve a buffer for a request
    input wire logic [2:0] alloc_idx, // Buffer to reserve
    input wire logic cpl_valid, // Completion returned
    input wire logic [2:0] cpl_idx, // Buffer of the completion
    input wire logic retry_valid, // PCI requester retried a read
    input wire logic [2:0] retry_idx, // Buffer of the retried read
    output bfh_pkg::bfh_rsp_type retry_rsp, // Answer to a timed-out retry
    output logic [7:0] buf_avail, // Buffers free for new requests
    input wire bfh_pkg::bfh_rx_type rx, // Received dword beat
    output bfh_pkg::bfh_fwd_type fwd, // Dword forwarded to PCI
    input wire bfh_pkg::bfh_term_in_type term, // Immediate PCI termination
    output bfh_pkg::bfh_cpl_out_type cpl_out, // Completion status to send
    input wire bfh_pkg::bfh_perr_type perr, // PERR seen on forwarded write
    input wire logic cor_err, // Correctable error event
    output bfh_pkg::bfh_msg_out_type msg // Error message to send
);

    // ===========================================================
    // Helpers
    function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                        input logic [31:0] clr);
        // Set beats clear in the same cycle
        w1c = (cur & ~clr) | set;
    endfunction

    localparam int NB = bfh_pkg::BFH_NUM_BUF;

    logic [31:0] bridge_ctrl_ff;
    logic [31:0] tmo_ctrl_ff;
    logic [31:0] err_ctrl_ff;
    logic [31:0] err_status_ff;
    logic [31:0] hdr_log_ff;
    logic [31:0] sec_hdr_log_ff;
    logic [31:0] irq_status_ff;
    logic [31:0] irq_mask_ff;
    logic [7:0] cbuf_status_ff;
    bfh_pkg::bfh_buf_state_type buf_state_ff [NB];
    logic [20:0] cnt_ff [NB];
    logic [1:0] reclaim_ff [NB];

    // ===========================================================
    // APB slave
    logic wr_en;
    logic setup;
    logic mapped;
    logic [31:0] rd_mux;
    logic [31:0] wr_cbuf;
    logic [31:0] wr_err;
    logic [31:0] wr_irq;

    assign wr_en = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            bfh_pkg::BFH_OFF_BRIDGE_CTRL: rd_mux = bridge_ctrl_ff;
            bfh_pkg::BFH_OFF_CBUF_STATUS: rd_mux = {24'h00_0000, cbuf_status_ff};
            bfh_pkg::BFH_OFF_TMO_CTRL: rd_mux = tmo_ctrl_ff;
            bfh_pkg::BFH_OFF_ERR_CTRL: rd_mux = err_ctrl_ff;
            bfh_pkg::BFH_OFF_ERR_STATUS: rd_mux = err_status_ff;
            bfh_pkg::BFH_OFF_HDR_LOG: rd_mux = hdr_log_ff;
            bfh_pkg::BFH_OFF_SEC_HDR_LOG: rd_mux = sec_hdr_log_ff;
            bfh_pkg::BFH_OFF_IRQ_STATUS: rd_mux = irq_status_ff;
            bfh_pkg::BFH_OFF_IRQ_MASK: rd_mux = irq_mask_ff;
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup so it comes from a flop in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    assign wr_cbuf = (wr_en && paddr == bfh_pkg::BFH_OFF_CBUF_STATUS) ? pwdata : 32'h0000_0000;
    assign wr_err = (wr_en && paddr == bfh_pkg::BFH_OFF_ERR_STATUS) ? pwdata : 32'h0000_0000;
    assign wr_irq = (wr_en && paddr == bfh_pkg::BFH_OFF_IRQ_STATUS) ? pwdata : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_ctrl_ff <= bfh_pkg::BFH_RST_BRIDGE_CTRL;
            tmo_ctrl_ff <= bfh_pkg::BFH_RST_TMO_CTRL;
            err_ctrl_ff <= bfh_pkg::BFH_RST_ERR_CTRL;
            irq_mask_ff <= 32'h0000_0000;
        end else if (wr_en) begin
            case (paddr)
                bfh_pkg::BFH_OFF_BRIDGE_CTRL: bridge_ctrl_ff <= pwdata;
                bfh_pkg::BFH_OFF_TMO_CTRL: tmo_ctrl_ff <= pwdata;
                bfh_pkg::BFH_OFF_ERR_CTRL: err_ctrl_ff <= pwdata;
                bfh_pkg::BFH_OFF_IRQ_MASK: irq_mask_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // ===========================================================
    // Completion buffer timeout and reclaim
    logic tmo_disabled;
    logic [20:0] tmo_limit;
    logic [20:0] long_limit;
    logic [7:0] status_set;
    logic [7:0] nxt_cbuf_status;
    logic [31:0] cbuf_w1c;
    logic all_exhausted;

    assign tmo_disabled = tmo_ctrl_ff[bfh_pkg::BFH_TC_DISABLE];
    assign long_limit = 21'(TMO_LONG_CYC);
    assign tmo_limit = tmo_ctrl_ff[bfh_pkg::BFH_TC_LONG] ? long_limit : 21'(TMO_SHORT_CYC);
    assign all_exhausted = &cbuf_status_ff;

    always_comb begin
        status_set = 8'h00;
        for (int i = 0; i < NB; i++) begin
            if (buf_state_ff[i] == bfh_pkg::BFH_BUF_WAIT && !(cpl_valid && cpl_idx == 3'(i))) begin
                if (tmo_disabled) begin
                    status_set[i] = (cnt_ff[i] + 21'h00_0001 >= long_limit);
                end else if (cnt_ff[i] + 21'h00_0001 >= tmo_limit) begin
                    status_set[i] = (reclaim_ff[i] == bfh_pkg::BFH_MAX_RECLAIM);
                end
            end
        end
    end

    assign cbuf_w1c = w1c({24'h00_0000, cbuf_status_ff}, {24'h00_0000, status_set}, wr_cbuf);

    // Lockup avoidance wins over everything once all eight are stuck
    assign nxt_cbuf_status = all_exhausted ? 8'h00 : cbuf_w1c[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbuf_status_ff <= 8'h00;
        end else begin
            cbuf_status_ff <= nxt_cbuf_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NB; i++) begin
                buf_state_ff[i] <= bfh_pkg::BFH_BUF_FREE;
                cnt_ff[i] <= 21'h00_0000;
                reclaim_ff[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < NB; i++) begin
                if ((wr_cbuf[i] && !status_set[i]) || all_exhausted) begin
                    buf_state_ff[i] <= bfh_pkg::BFH_BUF_FREE;
                    cnt_ff[i] <= 21'h00_0000;
                    reclaim_ff[i] <= 2'h0;
                end else if (cpl_valid && cpl_idx == 3'(i)) begin
                    buf_state_ff[i] <= bfh_pkg::BFH_BUF_FREE;
                    cnt_ff[i] <= 21'h00_0000;
                    reclaim_ff[i] <= 2'h0;
                end else if (alloc_valid && alloc_idx == 3'(i) && buf_avail[i]) begin
                    buf_state_ff[i] <= bfh_pkg::BFH_BUF_WAIT;
                    cnt_ff[i] <= 21'h00_0000;
                end else if (buf_state_ff[i] == bfh_pkg::BFH_BUF_WAIT) begin
                    if (tmo_disabled) begin
                        if (cnt_ff[i] + 21'h00_0001 >= long_limit) begin
                            // Stays reserved for a very late completion
                            buf_state_ff[i] <= bfh_pkg::BFH_BUF_STUCK;
                        end
                        cnt_ff[i] <= cnt_ff[i] + 21'h00_0001;
                    end else if (cnt_ff[i] + 21'h00_0001 >= tmo_limit) begin
                        buf_state_ff[i] <= bfh_pkg::BFH_BUF_REUSE;
                        cnt_ff[i] <= 21'h00_0000;
                        if (reclaim_ff[i] != bfh_pkg::BFH_MAX_RECLAIM) begin
                            reclaim_ff[i] <= reclaim_ff[i] + 2'h1;
                        end
                    end else begin
                        cnt_ff[i] <= cnt_ff[i] + 21'h00_0001;
                    end
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NB; i++) begin
            // A set status bit blocks reuse until software or lockup clear
            buf_avail[i] = (buf_state_ff[i] == bfh_pkg::BFH_BUF_FREE ||
                            buf_state_ff[i] == bfh_pkg::BFH_BUF_REUSE) && !cbuf_status_ff[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_rsp <= '0;
        end else begin
            retry_rsp.valid <= retry_valid && buf_state_ff[retry_idx] == bfh_pkg::BFH_BUF_REUSE;
            retry_rsp.target_abort <= bridge_ctrl_ff[bfh_pkg::BFH_BC_MASTER_ABORT_MODE];
            retry_rsp.data <= bridge_ctrl_ff[bfh_pkg::BFH_BC_MASTER_ABORT_MODE] ?
                              32'h0000_0000 : bfh_pkg::BFH_ALL_ONES;
        end
    end

    // ===========================================================
    // Forwarding path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd <= '0;
        end else begin
            fwd.valid <= rx.valid && !rx.ecrc_err;
            fwd.data <= rx.data;
            fwd.parity <= (^rx.data) ^ rx.poisoned;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_out <= '0;
        end else begin
            cpl_out.valid <= term.valid;
            cpl_out.poisoned <= 1'b0;
            cpl_out.status <= bfh_pkg::BFH_CPL_SC;
            case (term.kind)
                bfh_pkg::BFH_TERM_PARITY: begin
                    if (term.is_write) begin
                        cpl_out.status <= bfh_pkg::BFH_CPL_UR;
                    end else begin
                        cpl_out.poisoned <= 1'b1;
                    end
                end
                bfh_pkg::BFH_TERM_MABORT: cpl_out.status <= bfh_pkg::BFH_CPL_UR;
                bfh_pkg::BFH_TERM_TABORT: cpl_out.status <= bfh_pkg::BFH_CPL_CA;
                default: ;
            endcase
        end
    end

    // ===========================================================
    // Error detection and reporting
    logic poison_ev;
    logic ecrc_ev;
    logic perr_ev;
    logic poison_unmasked;
    logic poison_fatal;
    logic serr_en;
    logic msg_fatal;
    logic msg_nonfatal;
    logic msg_cor;
    logic [31:0] es_set;

    assign serr_en = err_ctrl_ff[bfh_pkg::BFH_EC_SERR_EN];
    assign poison_ev = rx.valid && rx.sop && rx.poisoned && !rx.ecrc_err;
    assign ecrc_ev = rx.valid && rx.sop && rx.ecrc_err;
    assign perr_ev = perr.valid && perr.poisoned_write;
    assign poison_unmasked = poison_ev && !err_ctrl_ff[bfh_pkg::BFH_EC_POISON_MASK];
    assign poison_fatal = err_ctrl_ff[bfh_pkg::BFH_EC_POISON_SEV];

    // PERR on a poisoned write is expected and never reported upstream
    assign msg_fatal = poison_unmasked && poison_fatal &&
                       (serr_en || err_ctrl_ff[bfh_pkg::BFH_EC_FATAL_EN]);
    assign msg_nonfatal = poison_unmasked && !poison_fatal &&
                          (serr_en || err_ctrl_ff[bfh_pkg::BFH_EC_NF_EN]);
    assign msg_cor = cor_err && err_ctrl_ff[bfh_pkg::BFH_EC_COR_EN];

    always_comb begin
        es_set = 32'h0000_0000;
        es_set[bfh_pkg::BFH_ES_COR_DET] = cor_err;
        es_set[bfh_pkg::BFH_ES_FATAL_DET] = poison_ev && poison_fatal;
        es_set[bfh_pkg::BFH_ES_NF_DET] = poison_ev && !poison_fatal;
        es_set[bfh_pkg::BFH_ES_DET_PARITY] = poison_ev || ecrc_ev;
        es_set[bfh_pkg::BFH_ES_MASTER_PAR] = poison_ev && rx.is_read_cpl &&
                                             err_ctrl_ff[bfh_pkg::BFH_EC_PERR_RESP];
        es_set[bfh_pkg::BFH_ES_POISONED] = poison_ev;
        es_set[bfh_pkg::BFH_ES_ECRC] = ecrc_ev;
        es_set[bfh_pkg::BFH_ES_SIG_SYS_ERR] = poison_unmasked && serr_en;
        es_set[bfh_pkg::BFH_ES_SEC_MASTER_PAR] = perr_ev &&
                                                 bridge_ctrl_ff[bfh_pkg::BFH_BC_SEC_PERR_RESP];
        es_set[bfh_pkg::BFH_ES_PERR_DET] = perr_ev;
        es_set[bfh_pkg::BFH_ES_FEP_ACTIVE] = poison_unmasked;
        es_set[bfh_pkg::BFH_ES_SEC_FEP_ACTIVE] = perr_ev &&
                                                 !err_ctrl_ff[bfh_pkg::BFH_EC_SPERR_MASK];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_status_ff <= 32'h0000_0000;
        end else begin
            err_status_ff <= w1c(err_status_ff, es_set, wr_err) & 32'h0000_0FFF;
        end
    end

    // Header logs freeze while their pointer is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_log_ff <= 32'h0000_0000;
            sec_hdr_log_ff <= 32'h0000_0000;
        end else begin
            if (poison_unmasked && !err_status_ff[bfh_pkg::BFH_ES_FEP_ACTIVE]) begin
                hdr_log_ff <= rx.header;
            end
            if (es_set[bfh_pkg::BFH_ES_SEC_FEP_ACTIVE] &&
                !err_status_ff[bfh_pkg::BFH_ES_SEC_FEP_ACTIVE]) begin
                sec_hdr_log_ff <= perr.header;
            end
        end
    end

    // One message per cycle; fatal outranks non-fatal outranks correctable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg <= '0;
        end else begin
            msg.valid <= msg_fatal || msg_nonfatal || msg_cor;
            if (msg_fatal) begin
                msg.kind <= bfh_pkg::BFH_MSG_FATAL;
            end else if (msg_nonfatal) begin
                msg.kind <= bfh_pkg::BFH_MSG_NONFATAL;
            end else begin
                msg.kind <= bfh_pkg::BFH_MSG_COR;
            end
        end
    end

    // ===========================================================
    // Interrupts
    logic [31:0] irq_set;

    always_comb begin
        irq_set = 32'h0000_0000;
        irq_set[bfh_pkg::BFH_IRQ_CBUF] = |status_set;
        irq_set[bfh_pkg::BFH_IRQ_MSG] = msg_fatal || msg_nonfatal || msg_cor;
        irq_set[bfh_pkg::BFH_IRQ_ECRC] = ecrc_ev;
        irq_set[bfh_pkg::BFH_IRQ_PERR] = perr_ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= 32'h0000_0000;
        end else begin
            irq_status_ff <= w1c(irq_status_ff, irq_set, wr_irq) & 32'h0000_000F;
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

endmodule

`default_nettype wire

//--- tb/bfh_fault_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module bfh_fault_monitor (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic cor_err, // Event
    input wire logic retry_valid, // Retry
    input wire bfh_pkg::bfh_rsp_type retry_rsp, // Answer
    input wire bfh_pkg::bfh_rx_type rx, // Beat in
    input wire bfh_pkg::bfh_fwd_type fwd, // Beat out
    input wire bfh_pkg::bfh_term_in_type term, // Ending
    input wire bfh_pkg::bfh_cpl_out_type cpl_out, // Status
    input wire bfh_pkg::bfh_perr_type perr, // PERR
    input wire bfh_pkg::bfh_msg_out_type msg // Message
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Port relations
    AST_PAR: assert property (rx.valid && !rx.ecrc_err |=> fwd.valid &&
        fwd.parity == (^$past(rx.data) ^ $past(rx.poisoned))) else $error("parity");
    AST_DROP: assert property (rx.valid && rx.ecrc_err |=> !fwd.valid) else $error("drop");
    AST_CA: assert property (term.valid && term.kind == 2'h3 |=>
        cpl_out.valid && cpl_out.status == 3'h4) else $error("abort");
    AST_UR: assert property (term.valid && (term.kind == 2'h2 || term.kind == 2'h1
        && term.is_write) |=> cpl_out.status == 3'h1) else $error("unsupported");
    AST_SCP: assert property (term.valid && term.kind == 2'h1 && !term.is_write |=>
        cpl_out.status == 3'h0 && cpl_out.poisoned) else $error("poisoned");
    AST_QUIET: assert property (perr.valid && !cor_err && !rx.valid |=> !msg.valid)
        else $error("perr message");
    AST_CAUSE: assert property (msg.valid |-> $past(cor_err || rx.valid && rx.poisoned))
        else $error("message");
    AST_RETRY: assert property (retry_rsp.valid |-> $past(retry_valid) &&
        retry_rsp.data == (retry_rsp.target_abort ? 32'h0 : 32'hFFFF_FFFF)) else $error("retry");
endmodule
bind bfh_fault_handler bfh_fault_monitor u_bfh_fault_monitor (.pclk, .presetn, .cor_err,
    .retry_valid, .retry_rsp, .rx, .fwd, .term, .cpl_out, .perr, .msg);
`default_nettype wire

//--- tb/bfh_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module bfh_far_model (
    input wire logic pclk, // Clock
    output var bfh_pkg::bfh_rx_type rx, // Packets in
    output var bfh_pkg::bfh_term_in_type term, // Bus endings
    output var bfh_pkg::bfh_perr_type perr // Target PERR
);
    initial begin
        rx = '0;
        term = '0;
        perr = '0;
    end
    // Idle data keeps moving, so a stale word never looks valid
    always @(negedge pclk) begin
        if (!rx.valid) begin
            rx.data <= ~rx.data;
        end
    end
    task automatic drive(input bfh_pkg::bfh_rx_type r, input logic [3:0] t, input logic p);
        @(posedge pclk);
        rx <= r;
        term <= t;
        perr <= '{p, p, 32'hC0DE_0002};
        @(posedge pclk);
        rx <= '{data: ~r.data, default: '0};
        term <= '0;
        perr <= '{1'h0, 1'h0, 32'h3F21_FFFD};
    endtask
endmodule
`default_nettype wire

//--- tb/bridge_fault_handling_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bridge_fault_handling_tb;
    localparam int SH = 16;
    localparam int LG = 64;
    localparam logic [31:0] D = 32'h8000_0003;
    localparam logic [31:0] HDR = 32'hC0DE_0001;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic alloc_valid = 1'h0, cpl_valid = 1'h0, retry_valid = 1'h0, cor_err = 1'h0;
    logic [2:0] alloc_idx = 3'h0, cpl_idx = 3'h0, retry_idx = 3'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq;
    logic [7:0] buf_avail;
    logic [7:0] ctl [5] = '{8'h00, 8'h02, 8'h04, 8'h24, 8'h48};
    logic [2:0] xm [5] = '{3'h0, 3'h4, 3'h5, 3'h0, 3'h7};
    int errors = 0, n_tests = 0;
    bfh_pkg::bfh_rx_type rx;
    bfh_pkg::bfh_fwd_type fwd;
    bfh_pkg::bfh_term_in_type term;
    bfh_pkg::bfh_cpl_out_type cpl_out;
    bfh_pkg::bfh_perr_type perr;
    bfh_pkg::bfh_msg_out_type msg;
    bfh_pkg::bfh_rsp_type retry_rsp;
    always #10 pclk = ~pclk;
    bfh_fault_handler #(.TMO_SHORT_CYC(SH), .TMO_LONG_CYC(LG)) u_bfh_fault_handler (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .alloc_valid, .alloc_idx, .cpl_valid, .cpl_idx, .retry_valid, .retry_idx, .retry_rsp,
        .buf_avail, .rx, .fwd, .term, .cpl_out, .perr, .cor_err, .msg);
    bfh_far_model u_bfh_far_model (.pclk, .rx, .term, .perr);
    // ==========
    // Access tasks
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        {psel, penable} <= 2'h0;
        @(negedge pclk);
    endtask
    task automatic ev(input logic [3:0] k, input logic [2:0] i);
        @(posedge pclk);
        {cor_err, retry_valid, cpl_valid, alloc_valid} <= k;
        {retry_idx, cpl_idx, alloc_idx} <= {3{i}};
        @(posedge pclk);
        {cor_err, retry_valid, cpl_valid, alloc_valid} <= 4'h0;
        @(negedge pclk);
    endtask
    task automatic tmo(input logic [2:0] i, input int n, input logic e);
        repeat (n - 1) @(posedge pclk);
        @(negedge pclk);
        chk(buf_avail[i], 1'h0);
        @(negedge pclk);
        chk(buf_avail[i], e);
    endtask
    task automatic pk(input logic [2:0] f);
        u_bfh_far_model.drive('{1'h1, 1'h1, f[2], f[1], f[0], HDR, D}, 4'h0, 1'h0);
        @(negedge pclk);
    endtask
    task automatic summarize();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Run takes under 3000 cycles, so this only trips on a hang
    initial begin
        #400000;
        errors++;
        summarize();
    end
    // ==========
    // Scenarios
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'hFA0, 32'h0);
        chk(rd, 32'h40);
        apb(1'h0, 12'h200, 32'h0);
        chk({pslverr, rd}, 33'h1_0000_0000);
        ev(4'h1, 3'h5);
        tmo(3'h5, LG, 1'h1);
        ev(4'h4, 3'h5);
        chk(retry_rsp, {2'h2, 32'hFFFF_FFFF});
        apb(1'h1, 12'h03C, 32'h0020_0001);
        ev(4'h4, 3'h5);
        chk(retry_rsp, 34'h3_0000_0000);
        ev(4'h2, 3'h5);
        apb(1'h1, 12'hFA0, 32'h0);
        for (int r = 0; r < 4; r++) begin
            for (int b = 0; b < (r < 3 ? 8 : 7); b++) begin
                ev(4'h1, b[2:0]);
            end
            repeat (SH + 4) @(posedge pclk);
            apb(1'h0, 12'hF88, 32'h0);
            chk({buf_avail, rd}, r < 3 ? 40'hFF_0000_0000 : 40'h80_0000_007F);
        end
        ev(4'h1, 3'h7);
        repeat (SH + 4) @(posedge pclk);
        apb(1'h0, 12'hF88, 32'h0);
        chk({buf_avail, rd}, 40'hFF_0000_0000);
        apb(1'h1, 12'hFA0, 32'h60);
        ev(4'h1, 3'h1);
        tmo(3'h1, LG, 1'h0);
        apb(1'h0, 12'hF88, 32'h0);
        chk(rd, 32'h2);
        apb(1'h1, 12'h114, 32'h0);
        chk(irq, 1'h0);
        apb(1'h1, 12'h114, 32'h1);
        chk(irq, 1'h1);
        apb(1'h1, 12'h110, 32'h1);
        chk(irq, 1'h0);
        apb(1'h1, 12'hF88, 32'h2);
        apb(1'h0, 12'hF88, 32'h0);
        chk({buf_avail, rd}, 40'hFF_0000_0000);
        apb(1'h1, 12'h100, 32'h51);
        pk(3'h5);
        chk({fwd, msg}, {1'h1, D, ~(^D), 3'h7});
        apb(1'h0, 12'h104, 32'h0);
        chk(rd, 32'h47C);
        apb(1'h0, 12'h108, 32'h0);
        chk(rd, HDR);
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 12'h100, {24'h0, ctl[i]});
            if (i < 2) ev(4'h8, 3'h0);
            else pk(3'h5);
            chk(msg, xm[i]);
        end
        apb(1'h0, 12'h104, 32'h0);
        chk(rd & 32'h5, 32'h5);
        pk(3'h2);
        chk({fwd.valid, msg}, 4'h0);
        for (int k = 1; k < 8; k++) begin
            if (k[1:0] != 2'h0) begin
                u_bfh_far_model.drive('0, {1'h1, k[2:0]}, 1'h0);
                @(negedge pclk);
                chk(cpl_out, k[1:0] == 2'h3 ? 5'h18 : (k[1:0] == 2'h2 || k[2]) ? 5'h12 : 5'h11);
            end
        end
        apb(1'h1, 12'h104, 32'hFFFF_FFFF);
        u_bfh_far_model.drive('0, 4'h0, 1'h1);
        @(negedge pclk);
        chk(msg.valid, 1'h0);
        apb(1'h0, 12'h104, 32'h0);
        chk(rd, 32'h980);
        summarize();
    end
endmodule
`default_nettype wire
